// ### mtlink_pkg.sv
/*
  Shared constants of the multiturn position reader: register offsets,
  field positions, reset values and link timing counts.
  Assumes a 125 MHz system clock and an AXI4-Lite register master.
*/
package mtlink_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] LEN_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR = 8'h0C;
  localparam logic [7:0] COUNT_ADDR = 8'h10;
  localparam logic [7:0] RXCNT_ADDR = 8'h14;
  localparam logic [7:0] PHASE_ADDR = 8'h18;

  // ----------------------------------------------------------------
  // Configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_FUNC_LSB = 0;     // Output function select, 2 bits
  localparam int CFG_PROTO_BIT = 2;    // 0 = SSI, 1 = BiSS C
  localparam int CFG_RATE_BIT = 3;     // 0 = slow, 1 = fast
  localparam int CFG_POLICY_BIT = 4;   // 0 = every frame loads, 1 = first only
  localparam int CFG_ALIGN_LSB = 5;    // align_bit_count, 2 bits
  localparam int CFG_DIR_BIT = 7;      // count_direction
  localparam int CFG_CLEAR_LSB = 8;    // turn_clear_policy, 2 bits
  localparam int CFG_CALSRC_BIT = 10;  // phase_cal_source
  localparam int CFG_TLEN_LSB = 11;    // turn_counter_len, 5 bits (0..24)
  localparam logic [1:0] FUNC_LINK = 2'h3;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Length word fields
  localparam int LEN_RC_LSB = 0;       // turn_count_len, 3 bits
  localparam int LEN_SKIP_LSB = 4;     // skip_bit_count, 4 bits
  localparam int LEN_FB_LSB = 8;       // feedback_bit_count, 2 bits
  localparam logic [9:0] LEN_RESET = 10'h000;

  // Control word bits
  localparam int CTRL_CLR_BIT = 0;     // Clear counter-written flag
  localparam int CTRL_START_BIT = 1;   // Request one frame

  // Status word bits
  localparam int ST_WRITTEN_BIT = 0;
  localparam int ST_MISMATCH_BIT = 1;
  localparam int ST_INVALID_BIT = 2;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_WARN_BIT = 4;
  localparam int ST_FAULT_LATCH_BIT = 5;
  localparam int ST_BUSY_BIT = 6;

  localparam int CRC_BITS = 6;
  localparam int MAX_ALIGN = 4;
  localparam int MAX_TURN = 24;
  localparam int PHASE_W = 14;         // 16,384 steps per turn

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int SLOW_HZ = 150_000;
  localparam int FAST_HZ = 1_500_000;
  localparam int TIMEOUT_NS = 20_000;  // Quiet time held after frame
  localparam int SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
  localparam int FAST_HALF = CLK_HZ / (2 * FAST_HZ);
  localparam int TIMEOUT_CYC = (TIMEOUT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage

// ### multiturn_position_reader.sv
/*
  Multiturn position reader: serial master for an external multiturn
  sensor, revolution counter load and compare, status flags, AXI4-Lite.
  Assumes the sensor data pin is asynchronous and synchronised here.
*/
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
//
// Functional notes
// - Master uses BiSS or SSI frame by select
// - BiSS: ignore CDS, never send CDM
// - BiSS: clock six CRC bits, unchecked
// - Clock held high after last bit
// - Rate bit selects link clock frequency
// - Policy 0 loads always; 1 first only
// - Load sets written flag until clear
// - After first load flag mismatching frames
// - Drop excess received count MSBs
// - Use up to four align bits
// - Clock and discard up to 15 skip bits
// - Feedback 1: fault bit or not ready
// - Feedback 2: also warning bit
// - Calibration source aligns zero to rollover
// - Angle shifted by offset times 360/16384
// - Latched fault held zero until valid frame
// - SSI: data high at first falling edge
// - BiSS: data high first two falling edges
// - Data low in timeout else invalid
// - Fields MSB first in fixed order
// - Clock out on pin A, data in pin B
// - Link enabled only when function is 3
// - Select 0 SSI, 1 BiSS C
// - Count length codes 0..6 by fours
`timescale 1ns/10ps
module multiturn_position_reader #(
  parameter int TIMEOUT_CYCLES = mtlink_pkg::TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [13:0] field_angle,
  input wire logic rollover_evt,
  output logic pin_a_out,
  input wire logic pin_b_in,
  output logic [13:0] shifted_angle,
  output logic phase_cal_evt
);

  initial begin
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 65535) $error("bad TIMEOUT_CYCLES");
    if (mtlink_pkg::SLOW_HALF > 512) $error("link half period exceeds divider");
  end

  typedef enum logic [2:0] {IDLE, LOW_HALF, HIGH_HALF, TIMEOUT} link_state_e;
  // Longest payload: count, align, skip, feedback and CRC
  localparam int SHIFT_W = mtlink_pkg::MAX_TURN + mtlink_pkg::MAX_ALIGN + 15 + 2
                           + mtlink_pkg::CRC_BITS;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_ff;
  logic [9:0] len_ff;
  logic [13:0] phase_ff;
  logic [23:0] turn_ff;
  logic [23:0] rx_turn_ff;
  logic loaded_ff, written_ff, mismatch_ff, invalid_ff;
  logic fault_ff, warn_ff, fault_latch_ff, start_ff;
  logic aw_ok_ff, w_ok_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic sync1_ff, sync2_ff;
  link_state_e state_ff;
  logic [8:0] div_ff;
  logic [15:0] tmo_ff;
  logic [6:0] bit_ff;
  logic [SHIFT_W-1:0] shift_ff;
  logic notready_ff;

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  wire link_on = cfg_ff[mtlink_pkg::CFG_FUNC_LSB +: 2] == mtlink_pkg::FUNC_LINK;
  wire biss = cfg_ff[mtlink_pkg::CFG_PROTO_BIT];
  wire fast = cfg_ff[mtlink_pkg::CFG_RATE_BIT];
  wire policy = cfg_ff[mtlink_pkg::CFG_POLICY_BIT];
  wire [1:0] align_code = cfg_ff[mtlink_pkg::CFG_ALIGN_LSB +: 2];
  wire cal_src = cfg_ff[mtlink_pkg::CFG_CALSRC_BIT];
  wire [4:0] tlen = cfg_ff[mtlink_pkg::CFG_TLEN_LSB +: 5];
  wire [2:0] rc_code = len_ff[mtlink_pkg::LEN_RC_LSB +: 3];
  wire [3:0] skip_n = len_ff[mtlink_pkg::LEN_SKIP_LSB +: 4];
  wire [1:0] fb_n = len_ff[mtlink_pkg::LEN_FB_LSB +: 2];
  wire [4:0] rc_bits = (rc_code > 3'h6) ? 5'h18 : {rc_code, 2'h0};
  // Code 0 selects four align bits, codes 1..3 that many
  wire [2:0] align_n = (align_code == 2'h0) ? 3'h4 : {1'b0, align_code};
  // Payload bits: count, align, skip, feedback, then CRC in BiSS
  wire [6:0] data_bits = 7'(rc_bits) + 7'(align_n) + 7'(skip_n) + 7'(fb_n);
  wire [6:0] total_bits = data_bits + (biss ? 7'(mtlink_pkg::CRC_BITS) : 7'h0);
  // Leading bits: BiSS has ack, start and CDS before data
  wire [6:0] lead_bits = biss ? 7'h3 : 7'h1;
  wire [6:0] frame_bits = lead_bits + total_bits;
  wire [8:0] half_cnt = fast ? 9'(mtlink_pkg::FAST_HALF - 1)
                             : 9'(mtlink_pkg::SLOW_HALF - 1);

  // Field extraction from the shifted frame
  function automatic logic [SHIFT_W-1:0] take_bits(input logic [SHIFT_W-1:0] word,
                                                   input logic [6:0] sh);
    take_bits = word >> sh;
  endfunction
  wire [6:0] tail_bits = total_bits - 7'(rc_bits);
  wire [SHIFT_W-1:0] rx_count_all = take_bits(shift_ff, tail_bits)
                                    & ((SHIFT_W'(1) << rc_bits) - SHIFT_W'(1));
  wire [6:0] fb_shift = biss ? 7'(mtlink_pkg::CRC_BITS) : 7'h0;
  wire [SHIFT_W-1:0] fb_word = take_bits(shift_ff, fb_shift);
  wire fault_n = (fb_n == 2'h2) ? fb_word[1] : fb_word[0];
  wire warn_n = fb_word[0];
  // Keep only what the counter holds
  wire [23:0] tmask = (tlen >= 5'h18) ? 24'hFFFFFF : ((24'h1 << tlen) - 24'h1);
  wire [23:0] rx_count = rx_count_all[23:0] & tmask;

  // ----------------------------------------------------------------
  // Link sampling and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    sync1_ff <= pin_b_in;
    sync2_ff <= sync1_ff;
  end

  wire half_done = div_ff == half_cnt;
  wire fall_edge = state_ff == HIGH_HALF && half_done;
  wire last_rise = state_ff == LOW_HALF && half_done && bit_ff == frame_bits - 7'h01;
  wire lead_phase = bit_ff < lead_bits;
  // Sensor not ready: data low on leading falling edges
  wire lead_bad = (bit_ff < (biss ? 7'h2 : 7'h1)) && !sync2_ff;
  wire frame_end = state_ff == TIMEOUT && tmo_ff == 16'(TIMEOUT_CYCLES - 1);
  // Data must be low through timeout
  wire frame_ok = !notready_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= IDLE;
      div_ff <= 9'h000;
      bit_ff <= 7'h00;
      tmo_ff <= 16'h0000;
      shift_ff <= '0;
      notready_ff <= 1'b0;
      pin_a_out <= 1'b1;
    end else begin
      unique case (state_ff)
        IDLE: begin
          pin_a_out <= 1'b1;
          div_ff <= 9'h000;
          bit_ff <= 7'h00;
          notready_ff <= 1'b0;
          if (start_ff && link_on) begin
            state_ff <= HIGH_HALF;
          end
        end
        HIGH_HALF: begin
          div_ff <= half_done ? 9'h000 : div_ff + 9'h001;
          if (half_done) begin
            pin_a_out <= 1'b0;
            state_ff <= LOW_HALF;
            if (lead_bad) begin
              notready_ff <= 1'b1;
            end
          end
        end
        LOW_HALF: begin
          div_ff <= half_done ? 9'h000 : div_ff + 9'h001;
          if (half_done) begin
            pin_a_out <= 1'b1;
            bit_ff <= bit_ff + 7'h01;
            // Sample at rising edge, MSB first; leading bits dropped
            if (!lead_phase) begin
              shift_ff <= {shift_ff[SHIFT_W-2:0], sync2_ff};
            end
            state_ff <= last_rise ? TIMEOUT : HIGH_HALF;
          end
        end
        TIMEOUT: begin
          pin_a_out <= 1'b1;
          tmo_ff <= frame_end ? 16'h0000 : tmo_ff + 16'h0001;
          if (sync2_ff && tmo_ff > 16'h0002) begin
            notready_ff <= 1'b1;
          end
          if (frame_end) begin
            state_ff <= IDLE;
          end
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter load, compare and flags
  // ----------------------------------------------------------------
  wire clr_req;
  wire valid_frame = frame_end && frame_ok;
  wire do_load = valid_frame && (!policy || !loaded_ff);
  wire differs = valid_frame && loaded_ff && rx_count != turn_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      turn_ff <= 24'h000000;
      rx_turn_ff <= 24'h000000;
      loaded_ff <= 1'b0;
      written_ff <= 1'b0;
      mismatch_ff <= 1'b0;
      invalid_ff <= 1'b0;
      fault_ff <= 1'b0;
      warn_ff <= 1'b0;
      fault_latch_ff <= 1'b0;
      phase_cal_evt <= 1'b0;
    end else begin
      phase_cal_evt <= cal_src && (rollover_evt || do_load);
      if (valid_frame) begin
        rx_turn_ff <= rx_count;
      end
      if (do_load) begin
        turn_ff <= rx_count;
        loaded_ff <= 1'b1;
      end
      // Set beats clear
      written_ff <= do_load || (written_ff && !clr_req);
      if (frame_end) begin
        mismatch_ff <= differs;
        invalid_ff <= !frame_ok;
        fault_ff <= !frame_ok || (fb_n != 2'h0 && !fault_n);
        warn_ff <= fb_n == 2'h2 && !warn_n && frame_ok;
      end
      // Latched fault only after a valid frame was seen
      if (loaded_ff && fault_ff) begin
        fault_latch_ff <= 1'b1;
      end else if (clr_req) begin
        fault_latch_ff <= 1'b0;
      end
    end
  end

  // Zero angle shifted by offset steps of 360/16384
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifted_angle <= 14'h0000;
    end else begin
      shifted_angle <= field_angle + phase_ff;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  wire hit_cfg = awaddr_ff == mtlink_pkg::CFG_ADDR;
  wire hit_len = awaddr_ff == mtlink_pkg::LEN_ADDR;
  wire hit_ctrl = awaddr_ff == mtlink_pkg::CTRL_ADDR;
  wire hit_phase = awaddr_ff == mtlink_pkg::PHASE_ADDR;
  wire wr_known = hit_cfg || hit_len || hit_ctrl || hit_phase;
  assign clr_req = wr_go && hit_ctrl && wstrb_ff[0] && wdata_ff[mtlink_pkg::CTRL_CLR_BIT];
  wire start_req = wr_go && hit_ctrl && wstrb_ff[0] && wdata_ff[mtlink_pkg::CTRL_START_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  wire [31:0] stat_word = {25'h0, state_ff != IDLE, fault_latch_ff, warn_ff, fault_ff,
                           invalid_ff, mismatch_ff, written_ff};
  logic [31:0] rd_word;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      mtlink_pkg::CFG_ADDR: rd_word = {16'h0, cfg_ff};
      mtlink_pkg::LEN_ADDR: rd_word = {22'h0, len_ff};
      mtlink_pkg::CTRL_ADDR: rd_word = 32'h0;
      mtlink_pkg::STAT_ADDR: rd_word = stat_word;
      mtlink_pkg::COUNT_ADDR: rd_word = {8'h0, turn_ff};
      mtlink_pkg::RXCNT_ADDR: rd_word = {8'h0, rx_turn_ff};
      mtlink_pkg::PHASE_ADDR: rd_word = {18'h0, phase_ff};
      default: begin
        rd_word = 32'h0;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      cfg_ff <= mtlink_pkg::CFG_RESET;
      len_ff <= mtlink_pkg::LEN_RESET;
      phase_ff <= 14'h0000;
      start_ff <= 1'b0;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      // Start only counts while the link is on; none is kept pending
      start_ff <= start_req && link_on;
      if (wr_go) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h3;
        if (hit_cfg) cfg_ff <= 16'(merge({16'h0, cfg_ff}, wdata_ff, wstrb_ff));
        if (hit_len) len_ff <= 10'(merge({22'h0, len_ff}, wdata_ff, wstrb_ff));
        if (hit_phase) phase_ff <= 14'(merge({18'h0, phase_ff}, wdata_ff, wstrb_ff));
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // multiturn_position_reader

// ### multiturn_position_reader_asserts.sv
/*
  Port checker for the multiturn position reader: link clock timing,
  calibration pulse and register bus handshakes.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module multiturn_position_reader_asserts #(
  parameter int TIMEOUT_CYCLES = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_a_out,
  input wire logic phase_cal_evt
);
  logic [15:0] lo_ff;
  logic [15:0] hi_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Lengths of the current low and high link clock stretches
  always_ff @(posedge aclk) begin
    if (!aresetn || pin_a_out) lo_ff <= 16'h0000;
    else lo_ff <= lo_ff + 16'h0001;
    if (!aresetn || !pin_a_out) hi_ff <= 16'h0000;
    else if (hi_ff != 16'hFFFF) hi_ff <= hi_ff + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  idle_reset_a: assert property (disable iff (1'b0) !aresetn |=> pin_a_out)
    else $error("link clock not high after reset");
  low_half_a: assert property ($rose(pin_a_out) |->
    (lo_ff == mtlink_pkg::FAST_HALF || lo_ff == mtlink_pkg::SLOW_HALF))
    else $error("link clock low half has wrong length");
  high_span_a: assert property ($fell(pin_a_out) |->
    (hi_ff == mtlink_pkg::FAST_HALF || hi_ff == mtlink_pkg::SLOW_HALF
     || hi_ff >= TIMEOUT_CYCLES))
    else $error("link clock high span too short");
  cal_pulse_a: assert property (phase_cal_evt |=> !phase_cal_evt)
    else $error("calibration pulse longer than one cycle");

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held over two cycles");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp[0] == s_axi_bresp[1])
    else $error("write response code not okay or decode error");

  frame_c: cover property ($rose(pin_a_out));
  cal_c: cover property (phase_cal_evt);
  decerr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'b11);
endmodule // multiturn_position_reader_asserts

// ### mt_sensor_model.sv
/*
  Behavioural external multiturn sensor on the serial link.
  Assumes the bench arms it before each frame with the bit pattern.
*/
`timescale 1ns/10ps
module mt_sensor_model (
  input wire logic link_clk,
  input wire logic arm,
  input wire logic ready,
  input wire logic late_fault,
  input wire logic [63:0] frame,
  input wire logic [6:0] nbits,
  output logic data_out
);
  int fall_cnt = 0;
  int rise_cnt = 0;
  initial data_out = 1'b0;

  // Idle level before a frame shows readiness
  always @(posedge arm) begin
    fall_cnt = 0;
    rise_cnt = 0;
    data_out <= #20 ready;
  end

  // Next bit, MSB first, after each falling clock edge; CRC included
  always @(negedge link_clk) begin
    fall_cnt++;
    if (fall_cnt <= nbits) data_out <= #20 frame[nbits - fall_cnt];
  end

  // Line low through timeout unless a fault is ordered
  always @(posedge link_clk) begin
    rise_cnt++;
    if (rise_cnt == nbits) data_out <= #1 late_fault;
  end
endmodule // mt_sensor_model

// ### multiturn_position_reader_bench.sv
/*
  Self-checking bench for the multiturn position reader.
  Assumes the sensor model and checker files are compiled alongside.
*/
`timescale 1ns/10ps
module multiturn_position_reader_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [13:0] field_angle = 14'h0000;
  logic [13:0] shifted_angle;
  logic rollover_evt = 1'b0;
  logic pin_a_out, pin_b_in, phase_cal_evt;
  logic [63:0] m_f = 64'h0;
  logic [6:0] m_n = 7'h00;
  logic m_rdy = 1'b0;
  logic m_lf = 1'b0;
  logic m_arm = 1'b0;
  int tests_run = 0;
  int bad_count = 0;
  int cal_seen = 0;

  always #4 aclk = ~aclk;

  // Count calibration pulses
  always @(posedge aclk) if (phase_cal_evt === 1'b1) cal_seen++;

  multiturn_position_reader #(.TIMEOUT_CYCLES(16)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .field_angle, .rollover_evt, .pin_a_out, .pin_b_in,
    .shifted_angle, .phase_cal_evt);

  mt_sensor_model sensor (.link_clk(pin_a_out), .arm(m_arm), .ready(m_rdy),
    .late_fault(m_lf), .frame(m_f), .nbits(m_n), .data_out(pin_b_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask

  // Config: function, protocol, rate, policy, counter length, feedback bits
  task automatic setup(input logic [1:0] fn, input logic p, input logic r,
                       input logic pol, input logic [4:0] tl, input logic [1:0] fb);
    wr(mtlink_pkg::CFG_ADDR, {16'h0, tl, 1'b0, 2'b00, 1'b0, 2'b00, pol, r, p, fn});
    wr(mtlink_pkg::LEN_ADDR, {22'h0, fb, 4'h4, 1'b0, 3'h3});
  endtask

  task automatic fr(input logic [63:0] f, input logic [6:0] n, input logic r, input logic l);
    @(posedge aclk);
    m_f <= f;
    m_n <= n;
    m_rdy <= r;
    m_lf <= l;
    m_arm <= 1'b1;
    @(posedge aclk);
    m_arm <= 1'b0;
    wr(mtlink_pkg::CTRL_ADDR, 32'h2);
    do rd(mtlink_pkg::STAT_ADDR); while (rdat[6] !== 1'b0);
  endtask

  function automatic logic [63:0] ssi(input logic ld, input logic [11:0] c, input logic [1:0] fb);
    ssi = 64'({ld, c, 8'h0F, fb});
  endfunction

  function automatic logic [63:0] bis(input logic [2:0] ld, input logic [11:0] c);
    bis = 64'({ld, c, 8'h0F, 2'b11, 6'h2A});
  endfunction

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(mtlink_pkg::CFG_ADDR, 32'hFFFF, 32'(mtlink_pkg::CFG_RESET));
    rchk(mtlink_pkg::LEN_ADDR, 32'h3FF, 32'(mtlink_pkg::LEN_RESET));
    rchk(mtlink_pkg::STAT_ADDR, 32'h7F, 32'h0);
    rd(8'h1C);
    chk({30'h0, rsp} | rdat, 32'h3);
    wr(8'h1C, 32'h1);
    chk({30'h0, rsp}, 32'h3);
    setup(2'h3, 1'b0, 1'b1, 1'b0, 5'd24, 2'd2);
    fr(ssi(1'b0, 12'hABC, 2'b11), 7'd23, 1'b0, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h29, 32'h08);
    fr(ssi(1'b1, 12'hABC, 2'b11), 7'd23, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h1F, 32'h01);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'hABC);
    fr(ssi(1'b1, 12'h123, 2'b11), 7'd23, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h3, 32'h3);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'h123);
    wr(mtlink_pkg::CTRL_ADDR, 32'h1);
    rchk(mtlink_pkg::STAT_ADDR, 32'h1, 32'h0);
    setup(2'h3, 1'b0, 1'b1, 1'b1, 5'd24, 2'd2);
    fr(ssi(1'b1, 12'h456, 2'b11), 7'd23, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h3, 32'h2);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'h123);
    setup(2'h3, 1'b0, 1'b1, 1'b0, 5'd8, 2'd2);
    fr(ssi(1'b1, 12'hABC, 2'b11), 7'd23, 1'b1, 1'b0);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'hBC);
    fr(ssi(1'b1, 12'h777, 2'b11), 7'd23, 1'b1, 1'b1);
    rchk(mtlink_pkg::STAT_ADDR, 32'hC, 32'hC);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'hBC);
    fr(ssi(1'b1, 12'hBC, 2'b00), 7'd23, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h18, 32'h18);
    setup(2'h3, 1'b0, 1'b1, 1'b0, 5'd8, 2'd1);
    fr(ssi(1'b1, 12'hBC, 2'b00) >> 1, 7'd22, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h18, 32'h08);
    setup(2'h3, 1'b1, 1'b1, 1'b0, 5'd24, 2'd2);
    fr(bis(3'b110, 12'h5A5), 7'd31, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h1C, 32'h0);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'h5A5);
    fr(bis(3'b010, 12'h5A5), 7'd31, 1'b1, 1'b0);
    rchk(mtlink_pkg::STAT_ADDR, 32'h8, 32'h8);
    setup(2'h3, 1'b0, 1'b0, 1'b0, 5'd24, 2'd2);
    fr(ssi(1'b1, 12'h321, 2'b11), 7'd23, 1'b1, 1'b0);
    rchk(mtlink_pkg::COUNT_ADDR, 32'hFFFFFF, 32'h321);
    setup(2'h0, 1'b0, 1'b1, 1'b0, 5'd24, 2'd2);
    wr(mtlink_pkg::CTRL_ADDR, 32'h2);
    repeat (60) @(posedge aclk);
    chk({31'h0, pin_a_out}, 32'h1);
    wr(mtlink_pkg::PHASE_ADDR, 32'h1000);
    field_angle <= 14'h3800;
    repeat (3) @(posedge aclk);
    chk({18'h0, shifted_angle}, 32'h0800);
    wr(mtlink_pkg::CFG_ADDR, 32'h0403);
    rollover_evt <= 1'b1;
    @(posedge aclk);
    rollover_evt <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(cal_seen != 0), 32'h1);
    test_done();
  end

  // Watchdog against a hung handshake or frame
  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    test_done();
  end
endmodule // multiturn_position_reader_bench

bind multiturn_position_reader multiturn_position_reader_asserts #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_a_out(pin_a_out), .phase_cal_evt(phase_cal_evt));
